// file: hdl/dcf_pkg.sv
package dcf_pkg;
  // Documented storage depth in 18-bit words
  localparam int DEPTH_DEF = 8192;
  localparam int DATA_W = 18;
  localparam int BYTE_W = 9;
  // Read-clock rising edges before a first word falls through
  localparam int FALL_EDGES = 3;
  // Preset offset pairs, indexed by {offset access, pick1, pick0}
  localparam logic [15:0] PRESET_OFF [8] = '{
    16'h0007, 16'h000F, 16'h001F, 16'h003F,
    16'h007F, 16'h00FF, 16'h01FF, 16'h03FF
  };

  // One sample of every pin except core_clk and rst; all of them cross into core_clk together
  typedef struct packed {
    logic write_clk;
    logic read_clk;
    logic write_enable_n;
    logic read_enable_n;
    logic output_enable_n;
    logic mode_serial_pin;
    logic write_width_select;
    logic read_width_select;
    logic byte_order_select;
    logic parity_position_select;
    logic retransmit_latency_select;
    logic flag_timing_select;
    logic default_offset_pick0;
    logic default_offset_pick1;
    logic offset_access_select_n;
    logic serial_load_enable_n;
    logic retransmit_request_n;
    logic full_reset_n;
    logic pointer_only_reset_n;
    logic [DATA_W-1:0] write_data_bus;
  } dcf_pins_t;

  // Mode selections latched during full reset
  typedef struct packed {
    logic fall_through_mode;
    logic write_narrow;
    logic read_narrow;
    logic little_endian;
    logic parity_interspersed;
    logic retransmit_normal;
    logic flag_sync;
  } dcf_cfg_t;
endpackage

// file: hdl/dcf_mem_if.sv
interface dcf_mem_if #(
  parameter int AW = 13
);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [dcf_pkg::DATA_W-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [dcf_pkg::DATA_W-1:0] rd_data;

  modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// file: hdl/dcf_store.sv
module dcf_store #(
  parameter int AW = 13
) (
  input wire logic core_clk,
  dcf_mem_if.store mem
);
  import dcf_pkg::*;

  typedef struct packed {
    logic [2**AW-1:0][DATA_W-1:0] word;
  } dcf_store_t;

  dcf_store_t st;
  dcf_store_t next_st;

  // Word storage; no reset, pointers decide what is valid
  always_comb begin
    next_st = st;
    if (mem.wr_en) begin
      next_st.word[mem.wr_addr] = mem.wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    st <= next_st;
  end

  // Read is combinational so a pop and a retransmit load land in one cycle
  assign mem.rd_data = st.word[mem.rd_addr];
endmodule

// file: hdl/dcf_top.sv
// Summary of operation
// - Write and read widths latched: 18 or 9
// - Write clock edge with enable stores word
// - Read clock edge with enable takes word
// - Read data driven only while output enabled
// - Clocks well below core rate, sampled safely into core
// - Fall-through: first word after three read edges
// - Timing mode latched at full reset
// - Standard mode: read data changes only on reads
// - Shared flags differ per mode; others always
// - Eight preset offset pairs loaded at reset
// - Serial offset load, one bit per edge
// - Parallel offset load from write bus
// - Offsets readable on read bus
// - Async almost flags: set one side, clear other
// - Sync almost flags: each on own clock
// - Almost-flag timing latched at full reset
// - Retransmit returns read pointer to start
// - Retransmit latency latched at full reset
// - Zero latency loads first word same edge
// - Full reset latches modes, clears pointers
// - Full reset drives documented flag levels
// - Pointer reset keeps modes and offsets
// - Byte order latched, picks narrow half first
module dcf_top #(
  parameter int DEPTH = dcf_pkg::DEPTH_DEF
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic write_clk,
  input wire logic read_clk,
  input wire logic write_enable_n,
  input wire logic read_enable_n,
  input wire logic output_enable_n,
  input wire logic mode_serial_pin,
  input wire logic write_width_select,
  input wire logic read_width_select,
  input wire logic byte_order_select,
  input wire logic parity_position_select,
  input wire logic retransmit_latency_select,
  input wire logic flag_timing_select,
  input wire logic default_offset_pick0,
  input wire logic default_offset_pick1,
  input wire logic offset_access_select_n,
  input wire logic serial_load_enable_n,
  input wire logic retransmit_request_n,
  input wire logic full_reset_n,
  input wire logic pointer_only_reset_n,
  input wire logic [dcf_pkg::DATA_W-1:0] write_data_bus,
  output logic [dcf_pkg::DATA_W-1:0] read_data_bus,
  output logic read_data_drive_n,
  output logic out_status_n,
  output logic in_status_n,
  output logic half_full_flag_n,
  output logic almost_empty_flag_n,
  output logic almost_full_flag_n
);
  import dcf_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW:0] HALF_CNT = (AW + 1)'(DEPTH / 2);
  localparam logic [1:0] FALL_LAST = 2'(FALL_EDGES - 1);

  // Depth must be a power of two so pointers wrap cleanly
  if (DEPTH != 2 ** AW || AW < 2 || AW > 16) begin : g_depth_check
    $error("dcf_top: DEPTH must be a power of two from 4 to 65536");
  end

  typedef struct packed {
    dcf_pins_t s1;
    dcf_pins_t s2;
    dcf_pins_t s3;
    dcf_cfg_t cfg;
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic [AW-1:0] ae_off;
    logic [AW-1:0] af_off;
    logic off_wsel;
    logic off_rsel;
    logic [BYTE_W-1:0] byte_hold;
    logic byte_have;
    logic [DATA_W-1:0] q;
    logic half_left;
    logic valid;
    logic [1:0] fw_wait;
    logic [DATA_W-1:0] qout;
    logic drive_n;
    logic ost_n;
    logic ist_n;
    logic half_n;
    logic ae_n;
    logic af_n;
  } dcf_state_t;

  dcf_state_t st;
  dcf_state_t next_st;
  dcf_pins_t pins;
  logic wr_edge;
  logic rd_edge;
  logic [AW:0] cnt;
  logic [AW:0] ncnt;
  logic mem_we;
  logic [DATA_W-1:0] mem_wd;
  logic [AW-1:0] mem_ra;
  logic [DATA_W-1:0] pval;
  logic [DATA_W-1:0] mem_rd;

  dcf_mem_if #(.AW(AW)) mem ();

  dcf_store #(.AW(AW)) u_store (
    .core_clk(core_clk),
    .mem(mem)
  );

  assign pins = '{write_clk, read_clk, write_enable_n, read_enable_n, output_enable_n,
    mode_serial_pin, write_width_select, read_width_select, byte_order_select,
    parity_position_select, retransmit_latency_select, flag_timing_select,
    default_offset_pick0, default_offset_pick1, offset_access_select_n,
    serial_load_enable_n, retransmit_request_n, full_reset_n, pointer_only_reset_n,
    write_data_bus};

  // Edges seen on the second stage; data taken from the stage before the edge
  assign wr_edge = st.s2.write_clk & ~st.s3.write_clk;
  assign rd_edge = st.s2.read_clk & ~st.s3.read_clk;
  assign cnt = st.wptr - st.rptr;
  assign mem_ra = (rd_edge && !st.s3.retransmit_request_n) ? '0 : st.rptr[AW-1:0];
  assign mem.wr_en = mem_we;
  assign mem.wr_addr = st.wptr[AW-1:0];
  assign mem.wr_data = mem_wd;
  assign mem.rd_addr = mem_ra;
  assign mem_rd = mem.rd_data;

  always_comb begin
    next_st = st;
    mem_we = 1'b0;
    mem_wd = '0;
    ncnt = cnt;
    pval = '0;
    next_st.s1 = pins;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.drive_n = st.s2.output_enable_n;
    if (!st.s2.full_reset_n) begin
      // Every mode is caught while full reset is held low
      next_st.cfg.fall_through_mode = st.s2.mode_serial_pin;
      next_st.cfg.write_narrow = st.s2.write_width_select;
      next_st.cfg.read_narrow = st.s2.read_width_select;
      next_st.cfg.little_endian = st.s2.byte_order_select;
      next_st.cfg.parity_interspersed = st.s2.parity_position_select;
      next_st.cfg.retransmit_normal = st.s2.retransmit_latency_select;
      next_st.cfg.flag_sync = st.s2.flag_timing_select;
      next_st.ae_off = AW'(PRESET_OFF[{st.s2.offset_access_select_n,
        st.s2.default_offset_pick1, st.s2.default_offset_pick0}]);
      next_st.af_off = next_st.ae_off;
      next_st.wptr = '0;
      next_st.rptr = '0;
      next_st.off_wsel = 1'b0;
      next_st.off_rsel = 1'b0;
      next_st.byte_have = 1'b0;
      next_st.q = '0;
      next_st.half_left = 1'b0;
      next_st.valid = 1'b0;
      next_st.fw_wait = '0;
      next_st.qout = '0;
      next_st.ost_n = st.s2.mode_serial_pin;
      next_st.ist_n = ~st.s2.mode_serial_pin;
      next_st.half_n = 1'b1;
      next_st.ae_n = 1'b0;
      next_st.af_n = 1'b1;
    end else if (!st.s2.pointer_only_reset_n) begin
      // Modes and offsets survive; flags follow an empty store
      next_st.wptr = '0;
      next_st.rptr = '0;
      next_st.byte_have = 1'b0;
      next_st.half_left = 1'b0;
      next_st.valid = 1'b0;
      next_st.fw_wait = '0;
      next_st.ost_n = st.cfg.fall_through_mode;
      next_st.ist_n = ~st.cfg.fall_through_mode;
      next_st.half_n = 1'b1;
      next_st.ae_n = 1'b0;
      next_st.af_n = 1'b1;
    end else begin
      // Write side: offset access takes the edge before data
      if (wr_edge) begin
        if (!st.s3.offset_access_select_n && !st.s3.serial_load_enable_n) begin
          {next_st.af_off, next_st.ae_off} =
            {st.af_off[AW-2:0], st.ae_off, st.s3.mode_serial_pin};
        end else if (!st.s3.offset_access_select_n && !st.s3.write_enable_n) begin
          // Interspersed parity drops bit 8 of a wide word
          pval = (st.cfg.parity_interspersed && !st.cfg.write_narrow) ?
            {1'b0, st.s3.write_data_bus[17:9], st.s3.write_data_bus[7:0]} :
            st.s3.write_data_bus;
          if (st.off_wsel) begin
            next_st.af_off = pval[AW-1:0];
          end else begin
            next_st.ae_off = pval[AW-1:0];
          end
          next_st.off_wsel = ~st.off_wsel;
        end else if (!st.s3.write_enable_n) begin
          if (st.cfg.write_narrow && !st.byte_have) begin
            next_st.byte_hold = st.s3.write_data_bus[BYTE_W-1:0];
            next_st.byte_have = 1'b1;
          end else if (cnt != FULL_CNT) begin
            mem_we = 1'b1;
            if (!st.cfg.write_narrow) begin
              mem_wd = st.s3.write_data_bus;
            end else if (st.cfg.little_endian) begin
              mem_wd = {st.s3.write_data_bus[BYTE_W-1:0], st.byte_hold};
            end else begin
              mem_wd = {st.byte_hold, st.s3.write_data_bus[BYTE_W-1:0]};
            end
            next_st.byte_have = 1'b0;
            next_st.wptr = st.wptr + 1'b1;
          end
        end
      end
      // Read side
      if (rd_edge) begin
        if (!st.s3.retransmit_request_n) begin
          next_st.rptr = '0;
          next_st.half_left = 1'b0;
          next_st.valid = 1'b0;
          next_st.fw_wait = '0;
          if (!st.cfg.retransmit_normal && st.wptr != '0) begin
            next_st.q = mem_rd;
            next_st.rptr = (AW + 1)'(1);
            next_st.half_left = st.cfg.read_narrow;
            next_st.valid = 1'b1;
          end
        end else if (!st.s3.offset_access_select_n && !st.s3.read_enable_n) begin
          next_st.q = DATA_W'(st.off_rsel ? st.af_off : st.ae_off);
          next_st.off_rsel = ~st.off_rsel;
          next_st.half_left = 1'b0;
        end else if (!st.s3.read_enable_n && (st.valid || !st.cfg.fall_through_mode)) begin
          if (st.cfg.read_narrow && st.half_left) begin
            next_st.half_left = 1'b0;
          end else if (cnt != '0) begin
            next_st.q = mem_rd;
            next_st.rptr = st.rptr + 1'b1;
            next_st.half_left = st.cfg.read_narrow;
          end else begin
            next_st.valid = 1'b0;
          end
        end
        // Fall-through fill counts read edges while the output is empty
        if (st.cfg.fall_through_mode && !next_st.valid && st.s3.retransmit_request_n
            && next_st.rptr == st.rptr && cnt != '0) begin
          if (st.fw_wait == FALL_LAST) begin
            next_st.q = mem_rd;
            next_st.rptr = st.rptr + 1'b1;
            next_st.half_left = st.cfg.read_narrow;
            next_st.valid = 1'b1;
            next_st.fw_wait = '0;
          end else begin
            next_st.fw_wait = st.fw_wait + 1'b1;
          end
        end
      end
      // Flags from the count after this cycle's moves
      ncnt = next_st.wptr - next_st.rptr;
      if (st.cfg.fall_through_mode) begin
        next_st.ost_n = ~next_st.valid;
        next_st.ist_n = (ncnt == FULL_CNT);
      end else begin
        next_st.ost_n = (ncnt != '0);
        next_st.ist_n = (ncnt != FULL_CNT);
      end
      next_st.half_n = ~(ncnt > HALF_CNT);
      if (st.cfg.flag_sync) begin
        if (rd_edge) begin
          next_st.ae_n = ~(ncnt <= {1'b0, st.ae_off});
        end
        if (wr_edge) begin
          next_st.af_n = ~(ncnt >= FULL_CNT - {1'b0, st.af_off});
        end
      end else begin
        // Async: each flag is set by one clock and released by the other
        if (rd_edge && ncnt <= {1'b0, st.ae_off}) begin
          next_st.ae_n = 1'b0;
        end
        if (wr_edge && ncnt > {1'b0, st.ae_off}) begin
          next_st.ae_n = 1'b1;
        end
        if (wr_edge && ncnt >= FULL_CNT - {1'b0, st.af_off}) begin
          next_st.af_n = 1'b0;
        end
        if (rd_edge && ncnt < FULL_CNT - {1'b0, st.af_off}) begin
          next_st.af_n = 1'b1;
        end
      end
      // Narrow reads show one half; standard mode moves only on reads
      if (!st.cfg.read_narrow) begin
        next_st.qout = next_st.q;
      end else if (next_st.half_left ^ st.cfg.little_endian) begin
        next_st.qout = {{BYTE_W{1'b0}}, next_st.q[17:9]};
      end else begin
        next_st.qout = {{BYTE_W{1'b0}}, next_st.q[8:0]};
      end
    end
    if (rst) begin
      next_st = '0;
      next_st.ist_n = 1'b1;
      next_st.half_n = 1'b1;
      next_st.af_n = 1'b1;
      next_st.drive_n = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    st <= next_st;
  end

  assign read_data_bus = st.qout;
  assign read_data_drive_n = st.drive_n;
  assign out_status_n = st.ost_n;
  assign in_status_n = st.ist_n;
  assign half_full_flag_n = st.half_n;
  assign almost_empty_flag_n = st.ae_n;
  assign almost_full_flag_n = st.af_n;

  // Checks on the design's own state
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic run;
  assign run = st.s2.full_reset_n && st.s2.pointer_only_reset_n;

  reset_levels_a: assert property (
    !st.s2.full_reset_n && !st.s2.mode_serial_pin |=> !out_status_n && in_status_n
      && !almost_empty_flag_n && almost_full_flag_n && half_full_flag_n && read_data_bus == '0)
    else $error("full reset flag levels wrong");
  ignore_full_a: assert property (
    run && wr_edge && cnt == FULL_CNT && st.s3.offset_access_select_n |=> $stable(st.wptr))
    else $error("write accepted while full");
  ignore_empty_a: assert property (
    run && rd_edge && cnt == '0 && st.s3.retransmit_request_n |=> $stable(st.rptr))
    else $error("read accepted while empty");
  write_store_a: assert property (
    run && wr_edge && !st.s3.write_enable_n && st.s3.offset_access_select_n
      && !st.cfg.write_narrow && cnt != FULL_CNT |=> st.wptr == $past(st.wptr) + 1'b1)
    else $error("word not stored");
  retransmit_ptr_a: assert property (
    run && rd_edge && !st.s3.retransmit_request_n |=> st.rptr <= (AW + 1)'(1))
    else $error("retransmit left read pointer away from start");
  drive_follow_a: assert property (
    st.s2.output_enable_n ##1 st.s2.output_enable_n |=> read_data_drive_n)
    else $error("read data driven while disabled");
  sync_ae_a: assert property (
    run && st.cfg.flag_sync && !rd_edge |=> $stable(almost_empty_flag_n))
    else $error("almost empty moved without read edge");
  sync_af_a: assert property (
    run && st.cfg.flag_sync && !wr_edge |=> $stable(almost_full_flag_n))
    else $error("almost full moved without write edge");
  mode_hold_a: assert property (
    st.s2.full_reset_n |=> $stable(st.cfg))
    else $error("modes changed outside full reset");
  std_output_a: assert property (
    run && !st.cfg.fall_through_mode && !rd_edge |=> $stable(read_data_bus))
    else $error("standard mode output moved without read");
  fall_wait_a: assert property (
    st.cfg.fall_through_mode && $rose(st.valid) |-> $past(rd_edge))
    else $error("fall-through word appeared off a read edge");

  fill_c: cover property (run && mem_we ##[1:50] st.ost_n);
  fall_c: cover property (st.cfg.fall_through_mode && $rose(st.valid));
  rtx_c: cover property (run && rd_edge && !st.s3.retransmit_request_n);
  full_c: cover property (run && cnt == FULL_CNT);
endmodule

// file: verification/dcf_far_end.sv
module dcf_far_end (
  input wire logic core_clk,
  input wire logic narrow,
  output logic write_clk,
  output logic read_clk,
  output logic write_enable_n,
  output logic read_enable_n,
  output logic retransmit_request_n,
  output logic [dcf_pkg::DATA_W-1:0] write_data_bus,
  output logic rd_mark
);
  timeunit 1ns;
  timeprecision 1ps;
  import dcf_pkg::*;
  // Extra low cycles per frame, so the far side can be slow
  int slow = 0;

  // Clocks rest low between frames, enables idle high
  initial begin
    {write_clk, read_clk, rd_mark} = 3'h0;
    {write_enable_n, read_enable_n, retransmit_request_n} = 3'h7;
    write_data_bus = 18'h0_0000;
  end

  // One frame: low, one rising edge, held high, low again
  task automatic frame(input logic wr);
    repeat (2 + slow) @(posedge core_clk);
    if (wr) begin
      write_clk <= 1'b1;
    end else begin
      read_clk <= 1'b1;
      rd_mark <= 1'b1;
    end
    @(posedge core_clk);
    rd_mark <= 1'b0;
    repeat (2) @(posedge core_clk);
    write_clk <= 1'b0;
    read_clk <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  // Enable and data stay put across the edge
  task automatic write_word(input logic en_n, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    write_enable_n <= en_n;
    write_data_bus <= narrow ? {9'h000, d[8:0]} : d;
    frame(1'b1);
    write_enable_n <= 1'b1;
    // Released bus shows the inverse, so a stale word cannot pass
    write_data_bus <= narrow ? {9'h000, ~d[8:0]} : ~d;
  endtask

  // Read enable held across the read edge
  task automatic read_word(input logic en_n, input logic rt_n);
    @(posedge core_clk);
    read_enable_n <= en_n;
    retransmit_request_n <= rt_n;
    frame(1'b0);
    read_enable_n <= 1'b1;
    retransmit_request_n <= 1'b1;
  endtask
endmodule

// file: verification/dcf_top_bench.sv
module dcf_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import dcf_pkg::*;
  localparam int DEPTH = 16;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic output_enable_n = 1'b0;
  // Serial offset pattern: upper nibble lands in the full offset
  localparam logic [7:0] SER_BITS = 8'h69;
  logic [8:0] mode = 9'h000;
  logic offset_access_select_n = 1'b0;
  logic serial_load_enable_n = 1'b1;
  logic full_reset_n = 1'b0;
  logic pointer_only_reset_n = 1'b1;
  logic write_clk, read_clk, write_enable_n, read_enable_n, retransmit_request_n, rd_mark;
  logic [DATA_W-1:0] write_data_bus, read_data_bus;
  logic read_data_drive_n, out_status_n, in_status_n;
  logic half_full_flag_n, almost_empty_flag_n, almost_full_flag_n;
  logic [DATA_W:0] expq[$];
  logic [DATA_W:0] e;
  logic [DATA_W-1:0] d [DEPTH];
  logic [31:0] lfsr = 32'h0000_6a69;
  int mismatches = 0;
  int checks = 0;

  always #2.5 core_clk = ~core_clk;

  dcf_top #(.DEPTH(DEPTH)) i_dut (
    .core_clk(core_clk), .rst(rst), .write_clk(write_clk), .read_clk(read_clk),
    .write_enable_n(write_enable_n), .read_enable_n(read_enable_n),
    .output_enable_n(output_enable_n), .mode_serial_pin(mode[7]),
    .write_width_select(mode[6]), .read_width_select(mode[5]),
    .byte_order_select(mode[4]), .parity_position_select(mode[3]),
    .retransmit_latency_select(mode[2]), .flag_timing_select(mode[1]),
    .default_offset_pick0(mode[0]), .default_offset_pick1(mode[8]),
    .offset_access_select_n(offset_access_select_n),
    .serial_load_enable_n(serial_load_enable_n),
    .retransmit_request_n(retransmit_request_n), .full_reset_n(full_reset_n),
    .pointer_only_reset_n(pointer_only_reset_n), .write_data_bus(write_data_bus),
    .read_data_bus(read_data_bus), .read_data_drive_n(read_data_drive_n),
    .out_status_n(out_status_n), .in_status_n(in_status_n),
    .half_full_flag_n(half_full_flag_n), .almost_empty_flag_n(almost_empty_flag_n),
    .almost_full_flag_n(almost_full_flag_n)
  );

  dcf_far_end i_far (
    .core_clk(core_clk), .narrow(mode[6]), .write_clk(write_clk), .read_clk(read_clk),
    .write_enable_n(write_enable_n), .read_enable_n(read_enable_n),
    .retransmit_request_n(retransmit_request_n), .write_data_bus(write_data_bus),
    .rd_mark(rd_mark)
  );

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check_data(input string what, input logic [DATA_W-1:0] exp,
                            input logic [DATA_W-1:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_flag(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask

  // Flags as {out, in, half, almost empty, almost full}, after they settle
  task automatic look(input logic [4:0] x);
    #1;
    check_flag("out_status_n", x[4], out_status_n);
    check_flag("in_status_n", x[3], in_status_n);
    check_flag("half_full_flag_n", x[2], half_full_flag_n);
    check_flag("almost_empty_flag_n", x[1], almost_empty_flag_n);
    check_flag("almost_full_flag_n", x[0], almost_full_flag_n);
  endtask

  // Note what the read must show, then let the far end clock it
  task automatic rd(input logic en_n, input logic rt_n, input logic [DATA_W-1:0] x);
    expq.push_back({1'b1, x});
    i_far.read_word(en_n, rt_n);
  endtask

  // Offset access low during full reset keeps the preset index in 0..3
  task automatic cfg(input logic [8:0] m);
    @(posedge core_clk);
    full_reset_n <= 1'b0;
    offset_access_select_n <= 1'b0;
    mode <= m;
    repeat (6) @(posedge core_clk);
    full_reset_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    offset_access_select_n <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic ptr_reset;
    @(posedge core_clk);
    pointer_only_reset_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    pointer_only_reset_n <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask

  // Output watcher: read data land three core edges after the read edge
  initial begin
    forever begin
      @(posedge core_clk);
      if (rd_mark === 1'b1) begin
        repeat (5) @(posedge core_clk);
        #1;
        if (expq.size() == 0) begin
          check_flag("read_queue", 1'b0, 1'b1);
        end else begin
          e = expq.pop_front();
          check_data("read_data_bus", e[DATA_W-1:0], read_data_bus);
        end
      end
    end
  end

  // A hang ends the run as a failure
  initial begin
    repeat (100000) @(posedge core_clk);
    check_flag("run_timeout", 1'b0, 1'b1);
    stop_test();
  end

  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    cfg(8'h00);
    look(5'b01101);
    check_data("read_data_bus", 18'h0_0000, read_data_bus);
    check_flag("read_data_drive_n", 1'b0, read_data_drive_n);
    @(posedge core_clk);
    output_enable_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    check_flag("read_data_drive_n", 1'b1, read_data_drive_n);
    @(posedge core_clk);
    output_enable_n <= 1'b0;
    // Fill to the brim at mixed far-end speeds
    for (int i = 0; i < DEPTH; i++) begin
      lfsr = next_rand(lfsr);
      d[i] = lfsr[DATA_W-1:0];
      i_far.slow = i % 3;
      i_far.write_word(1'b0, d[i]);
      if (i == 0) begin
        look(5'b11101);
        check_data("read_data_bus", 18'h0_0000, read_data_bus);
      end
    end
    look(5'b10010);
    i_far.write_word(1'b0, 18'h3_ffff);
    look(5'b10010);
    for (int i = 0; i < DEPTH; i++) rd(1'b0, 1'b1, d[i]);
    rd(1'b0, 1'b1, d[DEPTH-1]);
    look(5'b01101);
    // Retransmit after a pointer-only reset
    i_far.write_word(1'b0, d[5]);
    ptr_reset();
    look(5'b01101);
    for (int i = 0; i < 3; i++) i_far.write_word(1'b0, d[i]);
    rd(1'b0, 1'b1, d[0]);
    rd(1'b0, 1'b1, d[1]);
    rd(1'b1, 1'b0, d[0]);
    rd(1'b0, 1'b1, d[1]);
    rd(1'b0, 1'b1, d[2]);
    // Preset offsets read back, then overwritten in parallel
    @(posedge core_clk);
    offset_access_select_n <= 1'b0;
    rd(1'b0, 1'b1, 18'h0_0007);
    rd(1'b0, 1'b1, 18'h0_0007);
    // Serial load shifts a full new pair in, one bit per write edge
    @(posedge core_clk);
    serial_load_enable_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      @(posedge core_clk);
      mode[7] <= SER_BITS[i];
      i_far.write_word(1'b1, 18'h0_0000);
    end
    @(posedge core_clk);
    serial_load_enable_n <= 1'b1;
    mode[7] <= 1'b0;
    rd(1'b0, 1'b1, 18'(SER_BITS[3:0]));
    rd(1'b0, 1'b1, 18'(SER_BITS[7:4]));
    i_far.write_word(1'b0, 18'h0_0003);
    i_far.write_word(1'b0, 18'h0_0005);
    rd(1'b0, 1'b1, 18'h0_0003);
    rd(1'b0, 1'b1, 18'h0_0005);
    @(posedge core_clk);
    offset_access_select_n <= 1'b1;
    ptr_reset();
    for (int i = 0; i < 4; i++) i_far.write_word(1'b0, d[i]);
    look(5'b11111);
    // Narrow writer, big-endian halves into a wide word
    cfg(9'h141);
    i_far.write_word(1'b0, 18'h0_01a5);
    i_far.write_word(1'b0, 18'h0_005a);
    rd(1'b0, 1'b1, 18'h3_4a5a);
    // Preset three, cut to the pointer width of this depth
    @(posedge core_clk);
    offset_access_select_n <= 1'b0;
    rd(1'b0, 1'b1, 18'(PRESET_OFF[3] % DEPTH));
    rd(1'b0, 1'b1, 18'(PRESET_OFF[3] % DEPTH));
    @(posedge core_clk);
    offset_access_select_n <= 1'b1;
    // Narrow reader, little-endian order
    cfg(8'h34);
    i_far.write_word(1'b0, 18'h3_4a5a);
    rd(1'b0, 1'b1, 18'h0_005a);
    rd(1'b0, 1'b1, 18'h0_01a5);
    // Normal latency: retransmit leaves the output, next read restarts
    rd(1'b1, 1'b0, 18'h0_01a5);
    rd(1'b0, 1'b1, 18'h0_005a);
    // Fall-through: word appears on the third idle read edge
    cfg(8'h82);
    look(5'b10101);
    i_far.write_word(1'b0, d[7]);
    rd(1'b1, 1'b1, 18'h0_0000);
    rd(1'b1, 1'b1, 18'h0_0000);
    rd(1'b1, 1'b1, d[7]);
    look(5'b00101);
    for (int i = 0; i < 50 && expq.size() != 0; i++) @(posedge core_clk);
    if (expq.size() != 0) check_flag("read_queue", 1'b0, 1'b1);
    stop_test();
  end
endmodule
